// *** hdl/line_unit_pkg.sv ***
// constants, register layout and decode types of the line unit channel control bank
package line_unit_pkg;

   // ----------------
   // register map
   // ----------------
   localparam int NUM_CHANNELS = 2;
   localparam logic [15:0] LINE_CTRL_BASE = 16'h0F00;   // channel n at base + n*stride
   localparam logic [15:0] LINE_CTRL_STRIDE = 16'h0010;
   localparam logic [15:0] SEG_BASE_OFS = 16'h0008;      // first pulse segment of a channel
   localparam int NUM_SEGMENTS = 8;
   localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
   localparam logic [7:0] SEG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------
   // field positions
   // ----------------
   localparam int KIND_BIT = 7;
   localparam int ROUTE_BIT = 6;
   localparam int RX_ON_BIT = 5;
   localparam int CODE_MSB = 4;

   // ----------------
   // pattern lengths
   // ----------------
   localparam int PRBS_ORDER = 15;    // 2^15-1
   localparam int QRSS_ORDER = 20;    // 2^20-1
   localparam int PRBS_TAP = 14;      // x^15 + x^14 + 1
   localparam int QRSS_TAP = 17;      // x^20 + x^17 + 1
   localparam int QRSS_ZERO_RUN = 14; // qrss forces a one in place of the 14th zero in a row

   // ----------------
   // equalizer code boundaries
   // ----------------
   localparam logic [4:0] CODE_LH_36_LAST = 5'h03;
   localparam logic [4:0] CODE_LH_LAST = 5'h07;
   localparam logic [4:0] CODE_SH_LAST = 5'h0C;
   localparam logic [4:0] CODE_SH_ARB = 5'h0D;
   localparam logic [4:0] CODE_GAIN_FIRST = 5'h0E;
   localparam logic [4:0] CODE_GAIN_LAST = 5'h12;
   localparam logic [4:0] CODE_GAIN_ARB = 5'h13;
   localparam logic [4:0] CODE_GAIN_STEP_LAST = 5'h17;

   // ----------------
   // decode types
   // ----------------
   typedef enum logic [1:0] {
      SENS_15DB = 2'b00,
      SENS_29DB = 2'b01,
      SENS_36DB = 2'b10,
      SENS_45DB = 2'b11
   } sensitivity_t;

   typedef enum logic [1:0] {
      SHAPE_BUILD_OUT = 2'b00,   // long haul style attenuation
      SHAPE_CABLE = 2'b01,       // short haul cable range
      SHAPE_ARBITRARY = 2'b10,   // pulse segment table
      SHAPE_E1_TEMPLATE = 2'b11  // standard e1 template
   } shape_mode_t;

   typedef enum logic [1:0] {
      CABLE_TP100 = 2'b00,
      CABLE_COAX75 = 2'b01,
      CABLE_TP120 = 2'b10
   } cable_t;

   typedef enum logic [1:0] {
      HAUL_LONG = 2'b00,
      HAUL_SHORT = 2'b01,
      HAUL_GAIN = 2'b10
   } haul_t;

   // control register fields
   typedef struct packed {
      logic pattern_kind_select;   // 1 = qrss, 0 = prbs
      logic pattern_route_select;  // 1 = to rx outputs, 0 = to tx line
      logic receiver_power_on;
      logic [4:0] line_shape_code;
   } line_ctrl_t;

   // decoded line setup for the analog front end
   typedef struct packed {
      logic e1_mode;
      haul_t haul;
      sensitivity_t sensitivity;
      shape_mode_t shape;
      logic [2:0] transmit_build_out; // 0..3 build-out step or 0..4 cable range
      cable_t cable;
   } line_setup_t;

   // software register port
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage : line_unit_pkg

// *** hdl/pulse_segment_mem.sv ***
// small memory of arbitrary pulse segments, one bank per channel
`timescale 1ns/100ps
`default_nettype none

module pulse_segment_mem
   import line_unit_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // software write port
   input wire logic wr_en,
   input wire logic [3:0] wr_index,
   input wire logic [7:0] wr_data,
   // software read port
   input wire logic [3:0] rd_index,
   output logic [7:0] rd_data,
   // transmit shaper port
   input wire logic [3:0] tx_index,
   output logic [7:0] tx_data
);

   // ----------------
   // storage
   // ----------------
   logic [7:0] seg_r [NUM_CHANNELS*NUM_SEGMENTS];  // channel in index msb

   // writes land in the addressed entry
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_CHANNELS*NUM_SEGMENTS; i++) begin
            seg_r[i] <= SEG_RESET;
         end
      end else if (wr_en) begin
         seg_r[wr_index] <= wr_data;
      end
   end

   // registered read outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= SEG_RESET;
         tx_data <= SEG_RESET;
      end else begin
         rd_data <= seg_r[rd_index];
         tx_data <= seg_r[tx_index];
      end
   end

endmodule : pulse_segment_mem

`default_nettype wire

// *** hdl/line_unit_channel_control.sv ***
// per-channel line unit control registers, code decode and test pattern routing
// Operation
// - bit7 picks prbs15 or qrss20, reset 0
// - route 0 sends pattern to tx pair
// - route 1 sends pattern to rx outputs
// - receiver on powers receive section, accepts data
// - receiver off powers down all but pll
// - five bit code resets zero, decodes setup
// - codes 00-07 t1 long haul decode
// - codes 08-0D t1 short haul decode
// - codes 0E-17 t1 gain mode decode
// - codes 18-1F e1 pairs, coax or tp
// - arbitrary mode uses eight segment registers
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module line_unit_channel_control
   import line_unit_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // test pattern control, one per channel
   input wire logic [NUM_CHANNELS-1:0] pattern_enable,
   input wire logic [NUM_CHANNELS-1:0] pattern_clk_en,
   // normal transmit data per channel
   input wire logic [NUM_CHANNELS-1:0] tx_data_in,
   // receive line input pair per channel, from pins
   input wire logic [NUM_CHANNELS-1:0] rx_line_tip,
   input wire logic [NUM_CHANNELS-1:0] rx_line_ring,
   // transmit line output pair per channel
   output logic [NUM_CHANNELS-1:0] tx_line_tip,
   output logic [NUM_CHANNELS-1:0] tx_line_ring,
   // receive side outputs per channel
   output logic [NUM_CHANNELS-1:0] rx_positive_data_out,
   output logic [NUM_CHANNELS-1:0] rx_clock_out,
   // analog front end control per channel
   output logic [NUM_CHANNELS-1:0] rx_section_power,
   output logic [NUM_CHANNELS-1:0] master_clock_pll_power,
   output line_setup_t line_setup [NUM_CHANNELS],
   output logic [NUM_CHANNELS-1:0][7:0] tx_pulse_amplitude
);

   // ----------------
   // register port decode
   // ----------------
   reg_req_t req;                         // bundled request
   logic [NUM_CHANNELS-1:0] ctrl_hit;     // control register hit per channel
   logic [NUM_CHANNELS-1:0] seg_hit;      // segment register hit per channel
   logic [3:0] seg_index;                 // flat segment memory index
   logic seg_rd_r;                        // last read was a segment
   logic [7:0] ctrl_rdata_r;              // control readback stage
   logic [7:0] seg_rdata;                 // segment memory read data
   line_ctrl_t ctrl_r [NUM_CHANNELS];     // control register copies
   logic [3:0] tx_seg_idx_r [NUM_CHANNELS]; // segment walked by the shaper
   logic [3:0] tx_seg_flat;               // shaper index into memory
   logic [7:0] tx_seg_data;               // segment amplitude from memory
   logic shaper_sel_r;                    // channel the memory port serves

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // address compare and segment index
   always_comb begin
      seg_index = 4'h0;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         ctrl_hit[c] = (req.addr == 16'(LINE_CTRL_BASE + LINE_CTRL_STRIDE * c));
         seg_hit[c] = (req.addr >= 16'(LINE_CTRL_BASE + LINE_CTRL_STRIDE * c + SEG_BASE_OFS))
            && (req.addr < 16'(LINE_CTRL_BASE + LINE_CTRL_STRIDE * c + SEG_BASE_OFS
            + NUM_SEGMENTS));
         if (seg_hit[c]) begin
            seg_index = {1'(c), req.addr[2:0]};
         end
      end
   end

   // ----------------
   // per-channel control register and datapath
   // ----------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
         logic [QRSS_ORDER-1:0] lfsr_r;   // pattern shift register
         logic [3:0] zero_run_r;          // qrss zero run counter
         logic fb;                        // feedback bit
         logic pat_bit;                   // pattern output bit
         logic [1:0] tip_sync_r;          // rx tip synchroniser
         logic [1:0] ring_sync_r;         // rx ring synchroniser
         logic rx_data_r;                 // accepted receive data
         line_setup_t setup;              // decoded setup
         logic [4:0] code;                // equalizer code alias

         // software write; independent copy per channel
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               ctrl_r[ch] <= line_ctrl_t'(LINE_CTRL_RESET);
            end else if (req.wr && ctrl_hit[ch]) begin
               ctrl_r[ch] <= line_ctrl_t'(req.wdata);
            end
         end

         // feedback taps depend on selected sequence
         always_comb begin
            if (ctrl_r[ch].pattern_kind_select) begin
               fb = lfsr_r[QRSS_ORDER-1] ^ lfsr_r[QRSS_TAP-1];
            end else begin
               fb = lfsr_r[PRBS_ORDER-1] ^ lfsr_r[PRBS_TAP-1];
            end
         end

         // pattern generator, stepped by the line rate enable
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               lfsr_r <= '1;
               zero_run_r <= 4'h0;
            end else if (!pattern_enable[ch]) begin
               lfsr_r <= '1;
               zero_run_r <= 4'h0;
            end else if (pattern_clk_en[ch]) begin
               lfsr_r <= {lfsr_r[QRSS_ORDER-2:0], fb};
               if (fb) begin
                  zero_run_r <= 4'h0;
               end else if (zero_run_r != 4'(QRSS_ZERO_RUN)) begin
                  zero_run_r <= zero_run_r + 4'h1;
               end
            end
         end

         // qrss forces a one after the longest allowed zero run
         assign pat_bit = lfsr_r[0] |
            (ctrl_r[ch].pattern_kind_select && zero_run_r == 4'(QRSS_ZERO_RUN));

         // receive pins pass two synchroniser flops and a data flop; held idle when powered down
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               tip_sync_r <= 2'b00;
               ring_sync_r <= 2'b00;
               rx_data_r <= 1'b0;
            end else if (!ctrl_r[ch].receiver_power_on) begin
               tip_sync_r <= 2'b00;
               ring_sync_r <= 2'b00;
               rx_data_r <= 1'b0;
            end else begin
               tip_sync_r <= {tip_sync_r[0], rx_line_tip[ch]};
               ring_sync_r <= {ring_sync_r[0], rx_line_ring[ch]};
               rx_data_r <= tip_sync_r[1] ^ ring_sync_r[1];
            end
         end

         // output steering and power control
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               tx_line_tip[ch] <= 1'b0;
               tx_line_ring[ch] <= 1'b0;
               rx_positive_data_out[ch] <= 1'b0;
               rx_clock_out[ch] <= 1'b0;
            end else begin
               if (pattern_enable[ch] && !ctrl_r[ch].pattern_route_select) begin
                  tx_line_tip[ch] <= pat_bit;
                  tx_line_ring[ch] <= ~pat_bit;
               end else begin
                  tx_line_tip[ch] <= tx_data_in[ch];
                  tx_line_ring[ch] <= ~tx_data_in[ch];
               end
               if (pattern_enable[ch] && ctrl_r[ch].pattern_route_select) begin
                  rx_positive_data_out[ch] <= pat_bit;
                  rx_clock_out[ch] <= pattern_clk_en[ch];
               end else begin
                  rx_positive_data_out[ch] <= rx_data_r;
                  rx_clock_out[ch] <= ctrl_r[ch].receiver_power_on & pattern_clk_en[ch];
               end
            end
         end

         assign rx_section_power[ch] = ctrl_r[ch].receiver_power_on;
         assign master_clock_pll_power[ch] = 1'b1;

         // equalizer code decode table
         assign code = ctrl_r[ch].line_shape_code;
         always_comb begin
            setup = '{e1_mode: 1'b0, haul: HAUL_LONG, sensitivity: SENS_36DB,
                      shape: SHAPE_BUILD_OUT, transmit_build_out: 3'h0, cable: CABLE_TP100};
            if (code <= CODE_LH_LAST) begin
               setup.sensitivity = (code <= CODE_LH_36_LAST) ? SENS_36DB : SENS_45DB;
               setup.transmit_build_out = {1'b0, code[1:0]};
            end else if (code <= CODE_SH_ARB) begin
               setup.haul = HAUL_SHORT;
               setup.sensitivity = SENS_15DB;
               setup.shape = (code == CODE_SH_ARB) ? SHAPE_ARBITRARY : SHAPE_CABLE;
               setup.transmit_build_out = (code <= CODE_SH_LAST) ? 3'(code - 5'h08) : 3'h0;
            end else if (code <= CODE_GAIN_STEP_LAST) begin
               setup.haul = HAUL_GAIN;
               setup.sensitivity = SENS_29DB;
               if (code <= CODE_GAIN_LAST) begin
                  setup.shape = SHAPE_CABLE;
                  setup.transmit_build_out = 3'(code - CODE_GAIN_FIRST);
               end else if (code == CODE_GAIN_ARB) begin
                  setup.shape = SHAPE_ARBITRARY;
               end else begin
                  setup.transmit_build_out = {1'b0, code[1:0]};
               end
            end else begin
               setup.e1_mode = 1'b1;
               setup.shape = SHAPE_E1_TEMPLATE;
               setup.haul = (code[2:1] == 2'b00 || code[2:1] == 2'b01) ? HAUL_LONG :
                            (code[2:1] == 2'b10) ? HAUL_SHORT : HAUL_GAIN;
               case (code[2:1])
                  2'b00: setup.sensitivity = SENS_36DB;
                  2'b01: setup.sensitivity = SENS_45DB;
                  2'b10: setup.sensitivity = SENS_15DB;
                  default: setup.sensitivity = SENS_29DB;
               endcase
               setup.cable = code[0] ? CABLE_TP120 : CABLE_COAX75;
            end
         end

         // decoded setup leaves through a register
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               line_setup[ch] <= '0;
            end else begin
               line_setup[ch] <= setup;
            end
         end

         // shaper steps to the next of the eight segments each line enable
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               tx_seg_idx_r[ch] <= 4'h0;
               tx_pulse_amplitude[ch] <= 8'h00;
            end else begin
               if (pattern_clk_en[ch]) begin
                  tx_seg_idx_r[ch] <= {1'b0, tx_seg_idx_r[ch][2:0] + 3'h1};
               end
               if (setup.shape != SHAPE_ARBITRARY) begin
                  tx_pulse_amplitude[ch] <= 8'h00;
               end else if (shaper_sel_r == 1'(ch)) begin
                  tx_pulse_amplitude[ch] <= tx_seg_data;
               end
            end
         end
      end
   endgenerate

   // memory port alternates between channels
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shaper_sel_r <= 1'b0;
      end else begin
         shaper_sel_r <= ~shaper_sel_r;
      end
   end
   assign tx_seg_flat = {~shaper_sel_r, tx_seg_idx_r[~shaper_sel_r][2:0]};

   // ----------------
   // pulse segment storage
   // ----------------
   pulse_segment_mem u_segments (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wr_en(req.wr && (|seg_hit)),
      .wr_index(seg_index),
      .wr_data(req.wdata),
      .rd_index(seg_index),
      .rd_data(seg_rdata),
      .tx_index(tx_seg_flat),
      .tx_data(tx_seg_data)
   );

   // ----------------
   // read data, one cycle after the strobe
   // ----------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_rdata_r <= UNMAPPED_READ;
         seg_rd_r <= 1'b0;
      end else begin
         seg_rd_r <= req.rd && (|seg_hit);
         ctrl_rdata_r <= UNMAPPED_READ;
         for (int c = 0; c < NUM_CHANNELS; c++) begin
            if (req.rd && ctrl_hit[c]) begin
               ctrl_rdata_r <= ctrl_r[c];
            end
         end
      end
   end

   assign reg_rdata = seg_rd_r ? seg_rdata : ctrl_rdata_r;

endmodule : line_unit_channel_control

`default_nettype wire

// *** sim/line_unit_chk.sv ***
// concurrent checks on the line unit channel control ports
`timescale 1ns/100ps
`default_nettype none
module line_unit_chk
   import line_unit_pkg::*;
(
   // clock, reset and register port
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // channel side
   input wire logic [NUM_CHANNELS-1:0] pattern_enable,
   input wire logic [NUM_CHANNELS-1:0] pattern_clk_en,
   input wire logic [NUM_CHANNELS-1:0] rx_clock_out,
   input wire logic [NUM_CHANNELS-1:0] rx_section_power,
   input wire logic [NUM_CHANNELS-1:0] master_clock_pll_power,
   input wire line_setup_t line_setup [NUM_CHANNELS]
);
   // ----------------
   // shadow of the channel 0 control register
   // ----------------
   logic [7:0] ctrl0_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl0_r <= 8'h00;
      end else if (reg_wr && reg_addr == 16'h0F00) begin
         ctrl0_r <= reg_wdata;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ----------------
   // assertions
   // ----------------
   chk_rx_power: assert property (
      reg_wr && reg_addr == 16'h0F00 |=> rx_section_power[0] == ctrl0_r[5])
      else $error("rx power does not follow write");
   chk_other_chan: assert property (
      reg_wr && reg_addr == 16'h0F10 |=> $stable(rx_section_power[0]))
      else $error("channel 1 write disturbed channel 0");
   chk_read_back: assert property (
      reg_wr && reg_addr == 16'h0F00 ##1 reg_rd && reg_addr == 16'h0F00 |=> reg_rdata == ctrl0_r)
      else $error("control readback wrong");
   chk_unmapped_zero: assert property (
      reg_rd && reg_addr[15:5] != 11'h078 |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   chk_pll_kept: assert property (master_clock_pll_power == '1)
      else $error("master clock pll powered down");
   chk_rx_clk_off: assert property (
      !ctrl0_r[5] && !(ctrl0_r[6] && pattern_enable[0]) |=> !rx_clock_out[0])
      else $error("rx clock with receiver off");
   chk_route_clock: assert property (
      ctrl0_r[6] && pattern_enable[0] && pattern_clk_en[0] |=> rx_clock_out[0])
      else $error("pattern step missing on rx clock");
   chk_long_haul: assert property (
      $past(arst_n) && $stable(ctrl0_r) && ctrl0_r[4:3] == 2'b00 |->
      line_setup[0].sensitivity == (ctrl0_r[2] ? SENS_45DB : SENS_36DB) &&
      line_setup[0].transmit_build_out == {1'b0, ctrl0_r[1:0]})
      else $error("long haul decode wrong");
   chk_e1_cable: assert property (
      $past(arst_n) && $stable(ctrl0_r) && ctrl0_r[4:3] == 2'b11 |->
      line_setup[0].e1_mode && line_setup[0].cable == (ctrl0_r[0] ? CABLE_TP120 : CABLE_COAX75))
      else $error("e1 decode wrong");
   // main scenarios reached
   cov_wr_rd: cover property (reg_wr ##1 reg_rd);
   cov_route: cover property (ctrl0_r[6] && pattern_enable[0]);
   cov_arb: cover property (ctrl0_r[4:0] == 5'h0D);
endmodule : line_unit_chk
bind line_unit_channel_control line_unit_chk chk (.ref_clk, .arst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .pattern_enable, .pattern_clk_en, .rx_clock_out,
   .rx_section_power, .master_clock_pll_power, .line_setup);
`default_nettype wire

// *** sim/line_partner.sv ***
// far-end line model: drives the receive pair, counts marks on the channel 0 transmit pair
`timescale 1ns/100ps
`default_nettype none
module line_partner
   import line_unit_pkg::*;
(
   // clock and control from the bench
   input wire logic ref_clk,
   input wire logic [NUM_CHANNELS-1:0] send_mark,
   input wire logic clear_count,
   // line pins
   input wire logic [NUM_CHANNELS-1:0] tx_line_tip,
   input wire logic [NUM_CHANNELS-1:0] tx_line_ring,
   output logic [NUM_CHANNELS-1:0] rx_line_tip,
   output logic [NUM_CHANNELS-1:0] rx_line_ring,
   output logic [15:0] mark_count
);
   // no pulse on the receive pair is tip and ring both low
   initial begin
      rx_line_tip = '0;
      rx_line_ring = '0;
      mark_count = 16'h0000;
   end
   always @(posedge ref_clk) begin
      rx_line_tip <= send_mark;
      rx_line_ring <= '0;
      if (clear_count) begin
         mark_count <= 16'h0000;
      end else if (tx_line_tip[0] !== 1'b0 || tx_line_ring[0] !== 1'b1) begin
         mark_count <= mark_count + 16'h0001;
      end
   end
endmodule : line_partner
`default_nettype wire

// *** sim/line_unit_channel_control_test.sv ***
// self-checking bench for the line unit channel control bank
`timescale 1ns/100ps
`default_nettype none
module line_unit_channel_control_test
   import line_unit_pkg::*;
;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] pattern_enable = 2'b00, pattern_clk_en = 2'b00, tx_data_in = 2'b00;
   logic [1:0] send_mark = 2'b00;
   logic clear_count = 1'b1;
   logic [1:0] rx_tip, rx_ring, tx_tip, tx_ring, rx_pos, rx_clk, rx_pwr, pll_pwr;
   line_setup_t setup [NUM_CHANNELS];
   logic [1:0][7:0] amp;
   logic [15:0] mark_count;
   logic [31:0] seed = 32'h0E94D74B;
   logic [7:0] ctrl_m [NUM_CHANNELS] = '{8'h00, 8'h00}; // expected control per channel
   logic [1:0] div_r = 2'b00;
   int fail_count = 0;
   int num_checks = 0;
   int ones, clks;
   always #20 ref_clk = ~ref_clk;
   // line-rate step every fourth cycle
   always @(posedge ref_clk) begin
      div_r <= div_r + 2'b01;
      pattern_clk_en <= {2{div_r == 2'b00}};
   end
   line_unit_channel_control DUT (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pattern_enable, .pattern_clk_en, .tx_data_in, .rx_line_tip(rx_tip),
      .rx_line_ring(rx_ring), .tx_line_tip(tx_tip), .tx_line_ring(tx_ring),
      .rx_positive_data_out(rx_pos), .rx_clock_out(rx_clk), .rx_section_power(rx_pwr),
      .master_clock_pll_power(pll_pwr), .line_setup(setup), .tx_pulse_amplitude(amp));
   line_partner far_end (.ref_clk, .send_mark, .clear_count, .tx_line_tip(tx_tip),
      .tx_line_ring(tx_ring), .rx_line_tip(rx_tip), .rx_line_ring(rx_ring), .mark_count);
   // ----------------
   // expectation helpers
   // ----------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic line_setup_t exp_setup(input logic [4:0] c);
      line_setup_t e;
      e.e1_mode = c[4] & c[3];
      e.haul = (c <= 5'h07) ? HAUL_LONG : (c <= 5'h0D) ? HAUL_SHORT : HAUL_GAIN;
      if (e.e1_mode) e.haul = !c[2] ? HAUL_LONG : c[1] ? HAUL_GAIN : HAUL_SHORT;
      e.sensitivity = e.e1_mode ? sensitivity_t'({~c[2], c[1]}) :
         e.haul == HAUL_LONG ? sensitivity_t'({1'b1, c[2]}) :
         e.haul == HAUL_SHORT ? SENS_15DB : SENS_29DB;
      e.shape = e.e1_mode ? SHAPE_E1_TEMPLATE : (c == 5'h0D || c == 5'h13) ? SHAPE_ARBITRARY :
         (c <= 5'h07 || c >= 5'h14) ? SHAPE_BUILD_OUT : SHAPE_CABLE;
      e.transmit_build_out = e.shape == SHAPE_BUILD_OUT ? {1'b0, c[1:0]} :
         e.haul == HAUL_SHORT ? c[2:0] : 3'(c - 5'h0E);
      e.cable = !e.e1_mode ? CABLE_TP100 : c[0] ? CABLE_TP120 : CABLE_COAX75;
      return e;
   endfunction : exp_setup
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk8
   // build-out is not compared for arbitrary and e1 codes
   task automatic chk_setup(input logic [4:0] c, input line_setup_t got);
      logic [11:0] m;
      m = (c[4:3] == 2'b11 || c == 5'h0D || c == 5'h13) ? 12'hFE3 : 12'hFFF;
      num_checks++;
      if ((got & m) !== (exp_setup(c) & m)) begin
         fail_count++;
         $display("unexpected line_setup %h: expected %h, seen %h", c, exp_setup(c) & m, got & m);
      end
   endtask : chk_setup
   // ----------------
   // register bus tasks
   // ----------------
   task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : bus
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      @(negedge ref_clk);
      chk8("reg_rdata", exp, reg_rdata);
   endtask : rd_chk
   // write, then read straight back
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
      if (a[15:5] == 11'h078 && a[3:0] == 4'h0) ctrl_m[a[4]] = d;
      bus(1'b1, 1'b0, a, d);
      rd_chk(a, exp);
   endtask : wr_rd
   // count pattern ones, rx clocks and far-end marks
   task automatic count();
      @(posedge ref_clk);
      clear_count <= 1'b1;
      @(posedge ref_clk);
      clear_count <= 1'b0;
      ones = 0;
      clks = 0;
      repeat (64) begin
         @(negedge ref_clk);
         ones += int'(rx_pos[0] === 1'b1);
         clks += int'(rx_clk[0] !== 1'b0);
      end
   endtask : count
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   // ----------------
   // main sequence
   // ----------------
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd_chk(16'h0F00, 8'h00);
      rd_chk(16'h0F10, 8'h00);
      chk8("rx_section_power", 8'h00, 8'(rx_pwr));
      chk8("pll power", 8'h03, 8'(pll_pwr));
      wr_rd(16'h0F20, 8'hFF, 8'h00);
      for (int c = 0; c < 32; c++) begin
         wr_rd(16'h0F00, {3'b001, 5'(c)}, {3'b001, 5'(c)});
         chk_setup(5'(c), setup[0]);
      end
      // arbitrary pulse from both segment tables
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 1'b0, 16'h0F08 + 16'(i), 8'h5A);
         bus(1'b1, 1'b0, 16'h0F18 + 16'(i), 8'h3C);
      end
      wr_rd(16'h0F00, 8'h0D, 8'h0D);
      wr_rd(16'h0F10, 8'h13, 8'h13);
      rd_chk(16'h0F0F, 8'h5A);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk8("amplitude 0", 8'h5A, amp[0]);
      chk8("amplitude 1", 8'h3C, amp[1]);
      // pattern routing for both pattern kinds
      @(posedge ref_clk);
      pattern_enable <= 2'b01;
      for (int k = 0; k < 2; k++) begin
         wr_rd(16'h0F00, {k[0], 7'h00}, {k[0], 7'h00});
         count();
         chk8("tx marks seen", 8'h01, 8'(mark_count != 0));
         wr_rd(16'h0F00, {k[0], 7'h40}, {k[0], 7'h40});
         count();
         chk8("tx marks seen", 8'h00, 8'(mark_count != 0));
         chk8("rx pattern seen", 8'h01, 8'(ones != 0));
      end
      // receiver on and off with marks arriving
      @(posedge ref_clk);
      pattern_enable <= 2'b00;
      send_mark <= 2'b11;
      wr_rd(16'h0F00, 8'h20, 8'h20);
      count();
      chk8("rx data seen", 8'h01, 8'(ones != 0));
      chk8("rx clock seen", 8'h01, 8'(clks != 0));
      wr_rd(16'h0F00, 8'h00, 8'h00);
      count();
      chk8("rx clock seen", 8'h00, 8'(clks != 0));
      // random traffic on both channels
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         @(posedge ref_clk);
         tx_data_in <= seed[17:16];
         pattern_enable <= seed[19:18];
         send_mark <= seed[21:20];
         wr_rd({11'h078, seed[0], 4'h0}, seed[15:8], seed[15:8]);
         rd_chk({11'h078, ~seed[0], 4'h0}, ctrl_m[~seed[0]]);
         chk8("rx_section_power", 8'({ctrl_m[1][5], ctrl_m[0][5]}), 8'(rx_pwr));
         chk_setup(ctrl_m[1][4:0], setup[1]);
      end
      print_verdict();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      fail_count++;
      print_verdict();
   end
endmodule : line_unit_channel_control_test
`default_nettype wire
